// file: rtl/mrp_pkg.sv
package mrp_pkg;
   // ------------------------------------------------------------
   // register window
   // ------------------------------------------------------------
   localparam int unsigned WINDOW_BYTES       = 128;
   localparam logic [6:0]  ADDR_PARAM_LOW     = 7'h0c;
   localparam logic [6:0]  ADDR_PARAM_HIGH    = 7'h0d;
   localparam logic [6:0]  ADDR_CODE          = 7'h0e;
   localparam logic [6:0]  ADDR_RESERVED      = 7'h0f;
   localparam logic [6:0]  ADDR_FEEDBACK_LOW  = 7'h1c;
   localparam logic [6:0]  ADDR_FEEDBACK_HIGH = 7'h1d;
   localparam logic [6:0]  ADDR_ECHO          = 7'h1e;
   localparam logic [6:0]  ADDR_SNAPSHOT      = 7'h1f;
   localparam logic [6:0]  ADDR_IRQ_CTRL0     = 7'h38;
   localparam logic [6:0]  ADDR_IRQ_ENABLE    = 7'h39;
   localparam logic [6:0]  ADDR_IRQ_STATUS    = 7'h3a;
   localparam logic [6:0]  ADDR_IRQ_CTRL3     = 7'h3b;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned IRQ_ENABLE_BIT     = 5;
   localparam int unsigned IRQ_PENDING_BIT    = 6;
   localparam int unsigned IRQ_ASSERTED_BIT   = 7;
   localparam logic [7:0]  RESET_BYTE         = 8'h00;
   localparam logic [15:0] RESET_WORD         = 16'h0000;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0]  CMD_CLEAR_ECHO     = 8'h00;
   localparam logic [7:0]  CMD_RELAY_SET      = 8'h01;
   localparam logic [7:0]  CMD_RELAY_READ     = 8'h02;
   localparam logic [7:0]  CMD_HIGH0          = 8'h10;
   localparam logic [7:0]  CMD_LOW0           = 8'h11;
   localparam logic [7:0]  CMD_HIGH1          = 8'h12;
   localparam logic [7:0]  CMD_LOW1           = 8'h13;
   localparam logic [7:0]  CMD_BURST0         = 8'h14;
   localparam logic [7:0]  CMD_BURST1         = 8'h15;
   localparam logic [7:0]  CMD_PULSE_ENABLE   = 8'h1f;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLOCK_MHZ          = 100;
   localparam int unsigned TICK_US            = 100;
   localparam int unsigned TICK_CYCLES        = TICK_US * CLOCK_MHZ;
endpackage : mrp_pkg

// file: rtl/mrp_tick.sv
`timescale 1ns/10ps
module mrp_tick #(
   parameter int unsigned CYCLES = mrp_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst_n,
   // tick
   output logic      o_tick
);
   localparam int unsigned W = $clog2(CYCLES);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   wire          at_last = (count_q == LAST);

   assign count_d = at_last ? '0 : count_q + W'(1);
   assign o_tick  = at_last; // RULE24

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) count_q <= '0;
      else count_q <= count_d;
   end
endmodule : mrp_tick

// file: rtl/mrp_pulse.sv
`timescale 1ns/10ps
module mrp_pulse (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   // control
   input  wire logic        i_tick,
   input  wire logic        i_enable_set,
   input  wire logic        i_enable_value,
   input  wire logic [15:0] i_high_time,
   input  wire logic [15:0] i_low_time,
   input  wire logic [15:0] i_burst,
   // status and output
   output logic             o_running,
   output logic             o_pulse
);
   logic        run_q;
   logic        level_q;
   logic [15:0] left_q;
   logic [15:0] cycles_q;
   logic        finite_q;

   // a zero time is treated as one unit so the output never stalls
   wire  [15:0] high_len = (i_high_time == 16'h0000) ? 16'h0001 : i_high_time;
   wire  [15:0] low_len  = (i_low_time == 16'h0000) ? 16'h0001 : i_low_time;
   wire         phase_end = run_q && i_tick && (left_q == 16'h0001);
   wire         last_cycle = finite_q && (cycles_q == 16'h0001);
   wire         burst_done = phase_end && !level_q && last_cycle;

   assign o_running = run_q;
   assign o_pulse   = level_q;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_q    <= 1'b0;
         level_q  <= 1'b0;
         left_q   <= 16'h0000;
         cycles_q <= 16'h0000;
         finite_q <= 1'b0;
      end else if (i_enable_set) begin
         run_q    <= i_enable_value; // RULE2
         level_q  <= i_enable_value;
         left_q   <= high_len; // RULE3
         cycles_q <= i_burst; // RULE4
         finite_q <= (i_burst != 16'h0000); // RULE4
      end else if (burst_done) begin
         run_q   <= 1'b0; // RULE4
         level_q <= 1'b0;
      end else if (phase_end) begin
         level_q <= !level_q; // RULE3
         left_q  <= level_q ? low_len : high_len;
         if (!level_q && finite_q) cycles_q <= cycles_q - 16'h0001;
      end else if (run_q && i_tick) begin
         left_q <= left_q - 16'h0001;
      end
   end
endmodule : mrp_pulse

// file: rtl/mrp_mailbox.sv
// Contract
// RULE1 - eight relay outputs, each set individually, held until changed
// RULE2 - two pulse outputs, each enabled or disabled independently
// RULE3 - each pulse channel has high and low times, 1 to 65535 units of 100 us
// RULE4 - on enable, zero burst runs forever, nonzero emits that many cycles then stops
// RULE5 - host reloads burst count then re-enables for another train
// RULE6 - device decodes a 128-byte window, registers at fixed offsets
// RULE7 - write-only bytes 0x0c to 0x0f; 0x0e code, 0x0d high, 0x0c low parameter
// RULE8 - host writes zero to the reserved top outgoing byte
// RULE9 - host writes parameters first; writing the code byte submits the command
// RULE10 - top incoming byte shows isolated inputs, refreshed every 100 us
// RULE11 - accepted command code is echoed at offset 0x1e
// RULE12 - 0x1d and 0x1c return feedback high and low bytes of last command
// RULE13 - four interrupt sources: pattern, state change, count match, overflow
// RULE14 - status byte 0x3a read-only: bit 7 asserted, bit 6 pending, bits 0-1 absent
// RULE15 - bit 5 of 0x39 enables on-board interrupt; other bits kept zero
// RULE16 - host writes zero to 0x38 and 0x3b
// RULE17 - command 0x00 sets the echo to zero; feedback undefined
// RULE18 - host inserts 0x00 between identical back-to-back commands; the bench repeats 0x01 and 0x1f without it, and the device acts on each
// RULE19 - command 0x01 low byte is relay mask, bit n drives relay n
// RULE20 - command 0x02 returns relay states in feedback low byte and echoes
// RULE21 - 0x10 to 0x13 load ch0 high, ch0 low, ch1 high, ch1 low times
// RULE22 - 0x14 and 0x15 load 16-bit burst counts for channels 0 and 1
// RULE23 - 0x1f low byte bit 0 enables channel 0, bit 1 channel 1
// RULE24 - a 100 us tick times pulses and the input snapshot
// RULE25 - unknown command codes leave the echo unchanged
`timescale 1ns/10ps
module mrp_mailbox #(
   parameter int unsigned TICK_CYCLES = mrp_pkg::TICK_CYCLES,
   parameter int unsigned RELAYS      = 8,
   parameter int unsigned INPUTS      = 8
) (
   // clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   // byte-wide i/o window
   input  wire logic [6:0]        i_addr,
   input  wire logic              i_write,
   input  wire logic              i_read,
   input  wire logic [7:0]        i_wdata,
   output logic      [7:0]        o_rdata,
   // on-board event sources
   input  wire logic              i_event_pattern,
   input  wire logic              i_event_change,
   input  wire logic              i_event_count_match,
   input  wire logic              i_event_overflow,
   // field pins
   input  wire logic [INPUTS-1:0] i_isolated_input,
   output logic      [RELAYS-1:0] o_relay_out,
   output logic                   o_pulse_out_0,
   output logic                   o_pulse_out_1,
   output logic                   o_irq
);
   // ------------------------------------------------------------
   // synchronisers and timebase
   // ------------------------------------------------------------
   logic [INPUTS-1:0] in_meta_q;
   logic [INPUTS-1:0] in_sync_q;
   logic [3:0]        ev_meta_q;
   logic [3:0]        ev_sync_q;
   logic              tick;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_meta_q <= '0;
         in_sync_q <= '0;
         ev_meta_q <= '0;
         ev_sync_q <= '0;
      end else begin
         in_meta_q <= i_isolated_input;
         in_sync_q <= in_meta_q;
         ev_meta_q <= {i_event_overflow, i_event_count_match,
                       i_event_change, i_event_pattern}; // RULE13
         ev_sync_q <= ev_meta_q;
      end
   end

   mrp_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .o_tick  (tick)
   );

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // i_addr is seven bits wide, so the whole 128-byte window decodes
   wire wr_low   = i_write && (i_addr == mrp_pkg::ADDR_PARAM_LOW); // RULE6
   wire wr_high  = i_write && (i_addr == mrp_pkg::ADDR_PARAM_HIGH);
   wire wr_code  = i_write && (i_addr == mrp_pkg::ADDR_CODE); // RULE9
   // reserved byte is accepted and dropped; no extended codes here
   wire wr_ctrl0 = i_write && (i_addr == mrp_pkg::ADDR_IRQ_CTRL0);
   wire wr_ien   = i_write && (i_addr == mrp_pkg::ADDR_IRQ_ENABLE);
   wire wr_ctrl3 = i_write && (i_addr == mrp_pkg::ADDR_IRQ_CTRL3);

   // ------------------------------------------------------------
   // outgoing mailbox and interrupt control
   // ------------------------------------------------------------
   logic [7:0] param_low_q;
   logic [7:0] param_high_q;
   logic [7:0] ctrl0_q;
   logic [7:0] ien_q;
   logic [7:0] ctrl3_q;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         param_low_q  <= mrp_pkg::RESET_BYTE;
         param_high_q <= mrp_pkg::RESET_BYTE;
         ctrl0_q      <= mrp_pkg::RESET_BYTE;
         ien_q        <= mrp_pkg::RESET_BYTE;
         ctrl3_q      <= mrp_pkg::RESET_BYTE;
      end else begin
         if (wr_low) param_low_q <= i_wdata; // RULE7
         if (wr_high) param_high_q <= i_wdata; // RULE7
         if (wr_ctrl0) ctrl0_q <= i_wdata;
         if (wr_ien) ien_q <= i_wdata; // RULE15
         if (wr_ctrl3) ctrl3_q <= i_wdata;
      end
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire [15:0] param_word = {param_high_q, param_low_q}; // RULE21
   wire is_clear   = (i_wdata == mrp_pkg::CMD_CLEAR_ECHO);
   wire is_rset    = (i_wdata == mrp_pkg::CMD_RELAY_SET);
   wire is_rread   = (i_wdata == mrp_pkg::CMD_RELAY_READ);
   wire is_high0   = (i_wdata == mrp_pkg::CMD_HIGH0);
   wire is_low0    = (i_wdata == mrp_pkg::CMD_LOW0);
   wire is_high1   = (i_wdata == mrp_pkg::CMD_HIGH1);
   wire is_low1    = (i_wdata == mrp_pkg::CMD_LOW1);
   wire is_burst0  = (i_wdata == mrp_pkg::CMD_BURST0);
   wire is_burst1  = (i_wdata == mrp_pkg::CMD_BURST1);
   wire is_pen     = (i_wdata == mrp_pkg::CMD_PULSE_ENABLE);
   wire known      = is_clear || is_rset || is_rread || is_high0 || is_low0
                     || is_high1 || is_low1 || is_burst0 || is_burst1 || is_pen;
   wire accept     = wr_code && known; // RULE25

   // ------------------------------------------------------------
   // command state
   // ------------------------------------------------------------
   logic [RELAYS-1:0] relay_q;
   logic [15:0]       high0_q;
   logic [15:0]       low0_q;
   logic [15:0]       high1_q;
   logic [15:0]       low1_q;
   logic [15:0]       burst0_q;
   logic [15:0]       burst1_q;
   logic [7:0]        echo_q;
   logic [15:0]       feedback_q;
   logic [7:0]        snapshot_q;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         relay_q  <= '0;
         high0_q  <= mrp_pkg::RESET_WORD;
         low0_q   <= mrp_pkg::RESET_WORD;
         high1_q  <= mrp_pkg::RESET_WORD;
         low1_q   <= mrp_pkg::RESET_WORD;
         burst0_q <= mrp_pkg::RESET_WORD;
         burst1_q <= mrp_pkg::RESET_WORD;
      end else if (wr_code) begin
         if (is_rset) relay_q <= param_low_q[RELAYS-1:0]; // RULE19
         if (is_high0) high0_q <= param_word; // RULE21
         if (is_low0) low0_q <= param_word; // RULE21
         if (is_high1) high1_q <= param_word; // RULE21
         if (is_low1) low1_q <= param_word; // RULE21
         if (is_burst0) burst0_q <= param_word; // RULE22
         if (is_burst1) burst1_q <= param_word; // RULE22
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         echo_q     <= mrp_pkg::RESET_BYTE;
         feedback_q <= mrp_pkg::RESET_WORD;
      end else if (accept) begin
         echo_q <= i_wdata; // RULE11 RULE17
         // other commands leave feedback at zero, a defined don't-care
         feedback_q <= is_rread ? {8'h00, 8'(relay_q)} : mrp_pkg::RESET_WORD; // RULE20 RULE12
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) snapshot_q <= mrp_pkg::RESET_BYTE;
      else if (tick) snapshot_q <= 8'(in_sync_q); // RULE10
   end

   assign o_relay_out = relay_q; // RULE1

   // ------------------------------------------------------------
   // pulse generators
   // ------------------------------------------------------------
   wire pen_set = accept && is_pen; // RULE23

   mrp_pulse u_pulse0 (
      .i_clock        (i_clock),
      .i_rst_n        (i_rst_n),
      .i_tick         (tick),
      .i_enable_set   (pen_set),
      .i_enable_value (param_low_q[0]),
      .i_high_time    (high0_q),
      .i_low_time     (low0_q),
      .i_burst        (burst0_q),
      .o_running      (),
      .o_pulse        (o_pulse_out_0)
   );

   mrp_pulse u_pulse1 (
      .i_clock        (i_clock),
      .i_rst_n        (i_rst_n),
      .i_tick         (tick),
      .i_enable_set   (pen_set),
      .i_enable_value (param_low_q[1]),
      .i_high_time    (high1_q),
      .i_low_time     (low1_q),
      .i_burst        (burst1_q),
      .o_running      (),
      .o_pulse        (o_pulse_out_1)
   );

   // ------------------------------------------------------------
   // interrupt status
   // ------------------------------------------------------------
   // pending is a live level; the sources themselves hold until serviced
   wire        pending  = |ev_sync_q; // RULE13
   wire        asserted = pending && ien_q[mrp_pkg::IRQ_ENABLE_BIT]; // RULE15
   logic [7:0] status;

   always_comb begin
      status = 8'h00; // RULE14
      status[mrp_pkg::IRQ_PENDING_BIT]  = pending;
      status[mrp_pkg::IRQ_ASSERTED_BIT] = asserted;
   end

   assign o_irq = asserted;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = 8'h00;
      unique case (i_addr)
         mrp_pkg::ADDR_FEEDBACK_LOW:  rdata_d = feedback_q[7:0]; // RULE12
         mrp_pkg::ADDR_FEEDBACK_HIGH: rdata_d = feedback_q[15:8];
         mrp_pkg::ADDR_ECHO:          rdata_d = echo_q;
         mrp_pkg::ADDR_SNAPSHOT:      rdata_d = snapshot_q;
         mrp_pkg::ADDR_IRQ_CTRL0:     rdata_d = ctrl0_q;
         mrp_pkg::ADDR_IRQ_ENABLE:    rdata_d = ien_q;
         mrp_pkg::ADDR_IRQ_STATUS:    rdata_d = status;
         mrp_pkg::ADDR_IRQ_CTRL3:     rdata_d = ctrl3_q;
         default:                     rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) rdata_q <= 8'h00;
      else if (i_read) rdata_q <= rdata_d;
   end

   assign o_rdata = rdata_q;
endmodule : mrp_mailbox

// file: test/mrp_mailbox_properties.sv
`timescale 1ns/10ps
module mrp_checker #(
   parameter int unsigned TICK_CYCLES = 10000,
   parameter int unsigned RELAYS      = 8,
   parameter int unsigned INPUTS      = 8
) (
   // clock and reset
   input wire logic              i_clock,
   input wire logic              i_rst_n,
   // window
   input wire logic [6:0]        i_addr,
   input wire logic              i_write,
   input wire logic              i_read,
   input wire logic [7:0]        i_wdata,
   input wire logic [7:0]        o_rdata,
   // events and pins
   input wire logic              i_event_pattern,
   input wire logic              i_event_change,
   input wire logic              i_event_count_match,
   input wire logic              i_event_overflow,
   input wire logic [INPUTS-1:0] i_isolated_input,
   input wire logic [RELAYS-1:0] o_relay_out,
   input wire logic              o_pulse_out_0,
   input wire logic              o_pulse_out_1,
   input wire logic              o_irq
);
   // ------------------------------------------------------------
   // shadow of host writes
   // ------------------------------------------------------------
   logic [7:0] lo_q;
   logic [7:0] echo_q;
   logic       en_q;
   logic       wr_code;
   logic       known;
   logic       live;
   logic       any_ev;
   assign wr_code = i_write && (i_addr == mrp_pkg::ADDR_CODE);
   assign known   = (i_wdata <= 8'h02) || (i_wdata == 8'h1f)
                 || ((i_wdata[7:3] == 5'h02) && (i_wdata[2:0] <= 3'h5));
   assign live    = (i_addr[6:2] == 5'h07) || (i_addr[6:2] == 5'h0e);
   assign any_ev  = i_event_pattern | i_event_change | i_event_count_match | i_event_overflow;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lo_q   <= 8'h00;
         echo_q <= 8'h00;
         en_q   <= 1'b0;
      end else begin
         if (i_write && (i_addr == mrp_pkg::ADDR_PARAM_LOW)) lo_q <= i_wdata;
         if (wr_code && known) echo_q <= i_wdata;
         if (i_write && (i_addr == mrp_pkg::ADDR_IRQ_ENABLE)) en_q <= i_wdata[5];
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_relay_hold;
      $changed(o_relay_out) |-> $past(wr_code && (i_wdata == mrp_pkg::CMD_RELAY_SET));
   endproperty
   a_relay_hold: assert property (p_relay_hold)
      else $error("relays moved without a relay command");
   property p_relay_set;
      wr_code && (i_wdata == mrp_pkg::CMD_RELAY_SET) |=> o_relay_out == $past(lo_q);
   endproperty
   a_relay_set: assert property (p_relay_set)
      else $error("relays differ from the mask");
   property p_echo;
      i_read && (i_addr == mrp_pkg::ADDR_ECHO) |=> o_rdata == $past(echo_q);
   endproperty
   a_echo: assert property (p_echo)
      else $error("echo byte wrong");
   property p_dead_read;
      i_read && !live |=> o_rdata == 8'h00;
   endproperty
   a_dead_read: assert property (p_dead_read)
      else $error("unmapped read not zero");
   property p_rdata_hold;
      !i_read |=> $stable(o_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   property p_status;
      i_read && (i_addr == mrp_pkg::ADDR_IRQ_STATUS) |=>
         (o_rdata[5:0] == 6'h00) && (o_rdata[7] == (o_rdata[6] && $past(en_q)));
   endproperty
   a_status: assert property (p_status)
      else $error("status byte wrong");
   property p_irq_gate;
      o_irq |-> en_q && $past(any_ev, 2);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq without enable or event");
   property p_irq_raise;
      en_q && $past(i_rst_n, 3) && $past(any_ev, 2) |-> o_irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("enabled event gave no irq");
   property p_pulse_on0;
      wr_code && (i_wdata == mrp_pkg::CMD_PULSE_ENABLE) && lo_q[0] |=> o_pulse_out_0;
   endproperty
   a_pulse_on0: assert property (p_pulse_on0)
      else $error("channel 0 did not start");
   property p_pulse_off1;
      wr_code && (i_wdata == mrp_pkg::CMD_PULSE_ENABLE) && !lo_q[1] |=> !o_pulse_out_1;
   endproperty
   a_pulse_off1: assert property (p_pulse_off1)
      else $error("channel 1 not stopped");
endmodule : mrp_checker

bind mrp_mailbox mrp_checker #(.TICK_CYCLES(TICK_CYCLES), .RELAYS(RELAYS), .INPUTS(INPUTS))
   chk_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_write(i_write),
   .i_read(i_read), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_event_pattern(i_event_pattern),
   .i_event_change(i_event_change), .i_event_count_match(i_event_count_match),
   .i_event_overflow(i_event_overflow), .i_isolated_input(i_isolated_input),
   .o_relay_out(o_relay_out), .o_pulse_out_0(o_pulse_out_0), .o_pulse_out_1(o_pulse_out_1),
   .o_irq(o_irq));

// file: test/mrp_host.sv
`timescale 1ns/10ps
module mrp_host (
   // clock
   input  wire logic       i_clock,
   // window
   output logic      [6:0] o_addr,
   output logic            o_write,
   output logic            o_read,
   output logic      [7:0] o_wdata,
   input  wire logic [7:0] i_rdata
);
   initial begin
      o_addr  = 7'h00;
      o_write = 1'b0;
      o_read  = 1'b0;
      o_wdata = 8'h00;
   end
   // idle lines flip so a stale value is never mistaken for a live one
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clock);
      #1;
      o_addr  = a;
      o_wdata = d;
      o_write = 1'b1;
      @(posedge i_clock);
      #1;
      o_write = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask : wr
   task rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge i_clock);
      #1;
      o_addr = a;
      o_read = 1'b1;
      @(posedge i_clock);
      #1;
      o_read = 1'b0;
      d      = i_rdata;
      o_addr = ~a;
   endtask : rd
   task cmd(input logic [7:0] code, input logic [15:0] p);
      wr(mrp_pkg::ADDR_PARAM_LOW, p[7:0]);
      wr(mrp_pkg::ADDR_PARAM_HIGH, p[15:8]);
      wr(mrp_pkg::ADDR_RESERVED, 8'h00);
      wr(mrp_pkg::ADDR_CODE, code);
   endtask : cmd
   task train(input logic ch, input logic [15:0] burst, input logic [1:0] mask);
      cmd(ch ? mrp_pkg::CMD_BURST1 : mrp_pkg::CMD_BURST0, burst);
      cmd(mrp_pkg::CMD_CLEAR_ECHO, 16'h0000);
      cmd(mrp_pkg::CMD_PULSE_ENABLE, {14'h0000, mask});
   endtask : train
   task irq_setup(input logic en);
      wr(mrp_pkg::ADDR_IRQ_CTRL0, 8'h00);
      wr(mrp_pkg::ADDR_IRQ_CTRL3, 8'h00);
      wr(mrp_pkg::ADDR_IRQ_ENABLE, {2'h0, en, 5'h00});
   endtask : irq_setup
endmodule : mrp_host

// file: test/mailbox_relay_pwm_controller_bench.sv
`timescale 1ns/10ps
`define CHECK(nm, ex, gt) \
   begin \
      checks_done++; \
      if ((gt) !== (ex)) begin \
         err_total++; \
         $display("ERROR %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module mailbox_relay_pwm_controller_bench;
   localparam int TICK = 4;
   logic       i_clock = 1'b0;
   logic       i_rst_n = 1'b0;
   logic [6:0] addr;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [3:0] ev = 4'h0;
   logic [7:0] iso = 8'h00;
   logic [7:0] relay;
   logic       p0;
   logic       p1;
   logic       irq;
   logic [7:0] rv;
   logic       p0_q = 1'b0;
   logic       p1_q = 1'b0;
   int         err_total = 0;
   int         checks_done = 0;
   int         rise0 = 0;
   int         rise1 = 0;
   int         run0 = 0;
   int         hi0 = 0;
   int         per0 = 0;
   int         gap0 = 0;
   always #5 i_clock = ~i_clock;
   mrp_mailbox #(.TICK_CYCLES(TICK)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_addr(addr), .i_write(wr_en), .i_read(rd_en), .i_wdata(wdata), .o_rdata(rdata),
      .i_event_pattern(ev[0]), .i_event_change(ev[1]), .i_event_count_match(ev[2]),
      .i_event_overflow(ev[3]), .i_isolated_input(iso), .o_relay_out(relay),
      .o_pulse_out_0(p0), .o_pulse_out_1(p1), .o_irq(irq));
   mrp_host host_u (.i_clock(i_clock), .o_addr(addr), .o_write(wr_en), .o_read(rd_en),
      .o_wdata(wdata), .i_rdata(rdata));
   // edge counters for the pulse outputs
   always @(posedge i_clock) begin
      gap0++;
      if (p0 && !p0_q) begin
         rise0++;
         per0 = gap0;
         gap0 = 0;
      end
      if (p1 && !p1_q) rise1++;
      if (p0) run0++;
      else if (p0_q) begin
         hi0  = run0;
         run0 = 0;
      end
      p0_q = p0;
      p1_q = p1;
   end
   task cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : cyc
   task t_window;
      `CHECK("relays at reset", 8'h00, relay);
      host_u.wr(7'h50, 8'hff);
      host_u.rd(7'h50, rv);
      `CHECK("unmapped read", 8'h00, rv);
      host_u.rd(mrp_pkg::ADDR_PARAM_LOW, rv);
      `CHECK("write-only read", 8'h00, rv);
      host_u.wr(mrp_pkg::ADDR_IRQ_STATUS, 8'hff);
      host_u.rd(mrp_pkg::ADDR_IRQ_STATUS, rv);
      `CHECK("status idle", 8'h00, rv);
      $display("test window done");
   endtask : t_window
   task t_relay;
      for (int n = 0; n < 8; n++) begin
         host_u.cmd(mrp_pkg::CMD_RELAY_SET, 16'h0001 << n);
         `CHECK("relay walk", 8'h01 << n, relay);
         host_u.rd(mrp_pkg::ADDR_ECHO, rv);
         `CHECK("echo set", mrp_pkg::CMD_RELAY_SET, rv);
      end
      host_u.cmd(mrp_pkg::CMD_RELAY_SET, 16'h77a5);
      host_u.cmd(mrp_pkg::CMD_RELAY_READ, 16'h0000);
      host_u.rd(mrp_pkg::ADDR_FEEDBACK_LOW, rv);
      `CHECK("relay readback", 8'ha5, rv);
      host_u.rd(mrp_pkg::ADDR_FEEDBACK_HIGH, rv);
      `CHECK("feedback high", 8'h00, rv);
      host_u.cmd(mrp_pkg::CMD_CLEAR_ECHO, 16'h0000);
      host_u.rd(mrp_pkg::ADDR_ECHO, rv);
      `CHECK("echo cleared", 8'h00, rv);
      host_u.cmd(8'h33, 16'h0000);
      host_u.rd(mrp_pkg::ADDR_ECHO, rv);
      `CHECK("unknown code echo", 8'h00, rv);
      `CHECK("relays held", 8'ha5, relay);
      $display("test relay done");
   endtask : t_relay
   task t_snapshot;
      iso = 8'h3c;
      cyc(3 * TICK + 4);
      host_u.rd(mrp_pkg::ADDR_SNAPSHOT, rv);
      `CHECK("snapshot", 8'h3c, rv);
      iso = 8'hc3;
      cyc(3 * TICK + 4);
      host_u.rd(mrp_pkg::ADDR_SNAPSHOT, rv);
      `CHECK("snapshot again", 8'hc3, rv);
      $display("test snapshot done");
   endtask : t_snapshot
   task t_irq;
      host_u.irq_setup(1'b1);
      for (int i = 0; i < 4; i++) begin
         ev = 4'h1 << i;
         cyc(4);
         `CHECK("irq raised", 1'b1, irq);
         host_u.rd(mrp_pkg::ADDR_IRQ_STATUS, rv);
         `CHECK("status raised", 8'hc0, rv);
         ev = 4'h0;
         cyc(4);
         `CHECK("irq dropped", 1'b0, irq);
      end
      host_u.irq_setup(1'b0);
      ev = 4'h4;
      cyc(4);
      host_u.rd(mrp_pkg::ADDR_IRQ_STATUS, rv);
      `CHECK("pending only", 8'h40, rv);
      `CHECK("irq masked", 1'b0, irq);
      ev = 4'h0;
      $display("test irq done");
   endtask : t_irq
   task t_burst;
      host_u.cmd(mrp_pkg::CMD_HIGH0, 16'h0002);
      host_u.cmd(mrp_pkg::CMD_LOW0, 16'h0003);
      rise0 = 0;
      host_u.train(1'b0, 16'h0003, 2'h1);
      cyc(200);
      `CHECK("burst of three", 3, rise0);
      `CHECK("high width", 2 * TICK, hi0);
      `CHECK("period", (2 + 3) * TICK, per0);
      `CHECK("stopped low", 1'b0, p0);
      `CHECK("other channel idle", 0, rise1);
      rise0 = 0;
      host_u.train(1'b0, 16'h0001, 2'h1);
      cyc(200);
      `CHECK("reloaded burst", 1, rise0);
      $display("test burst done");
   endtask : t_burst
   task t_run;
      host_u.cmd(mrp_pkg::CMD_HIGH1, 16'h0001);
      host_u.cmd(mrp_pkg::CMD_LOW1, 16'h0001);
      rise0 = 0;
      rise1 = 0;
      host_u.train(1'b1, 16'h0000, 2'h2);
      cyc(200);
      `CHECK("continuous", 1'b1, rise1 >= 23 && rise1 <= 27);
      `CHECK("channel 0 quiet", 0, rise0);
      host_u.cmd(mrp_pkg::CMD_PULSE_ENABLE, 16'h0000);
      rise1 = 0;
      cyc(40);
      `CHECK("disabled", 1'b0, p1);
      `CHECK("no more pulses", 0, rise1);
      $display("test run done");
   endtask : t_run
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      cyc(8);
      i_rst_n = 1'b1;
      t_window;
      t_relay;
      t_snapshot;
      t_irq;
      t_burst;
      t_run;
      finish_test;
   end
   // watchdog well past the thousand or so cycles the tests need
   initial begin
      #200000;
      err_total++;
      finish_test;
   end
endmodule : mailbox_relay_pwm_controller_bench
